// File: design/tsbsp_defs.svh
`ifndef TSBSP_DEFS_SVH
`define TSBSP_DEFS_SVH
// slot geometry
`define TSBSP_SLOTS_PER_FRAME 84
`define TSBSP_BITS_PER_SLOT 8
`define TSBSP_STUFF_DELAY 8
// stuff pattern sent in a stuffed slot
`define TSBSP_STUFF_BYTE 8'hFF
// reset values
`define TSBSP_TXD_RST 1'b1
`endif

// File: design/tsbsp_pkg.sv
package tsbsp_pkg;
    // per-lane state: synchronisers, edge tracking, slot position, stuff delay
    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] stb_s;
        logic [1:0] tst_s;
        logic [1:0] rd_s;
        logic [1:0] rst_s;
        logic clk_prev;
        logic in_frame;
        logic [6:0] slot;
        logic [2:0] bitn;
        logic [7:0] stuff_pipe;
        logic cur_stuffed;
        logic [7:0] tx_byte;
        logic [7:0] rx_sh;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic txd;
    } tsbsp_lane_t;
endpackage

// File: design/tsbsp_slot_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsbsp_defs.svh"
module tsbsp_slot_port
    import tsbsp_pkg::*;
#(
    parameter int SLOTS = `TSBSP_SLOTS_PER_FRAME
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // payload bus from master
    input wire logic payload_bus_clock,
    input wire logic payload_frame_strobe,
    input wire logic payload_tx_stuff_request,
    input wire logic payload_rx_serial_data,
    input wire logic payload_rx_stuff_flag,
    // payload bus to master
    output logic payload_tx_serial_data,
    output logic tx_sync_indication,
    // overhead bus from master
    input wire logic overhead_bus_clock,
    input wire logic overhead_frame_strobe,
    input wire logic overhead_tx_stuff_request,
    input wire logic overhead_rx_serial_data,
    input wire logic overhead_rx_stuff_flag,
    // overhead bus to master
    output logic overhead_tx_serial_data,
    // user side: transmit bytes, taken at each slot start that is not stuffed
    input wire logic [7:0] payload_tx_byte,
    input wire logic payload_tx_sync_req,
    input wire logic [7:0] overhead_tx_byte,
    // user side: received bytes
    output logic [7:0] payload_rx_byte,
    output logic payload_rx_valid,
    output logic [7:0] overhead_rx_byte,
    output logic overhead_rx_valid,
    output logic [6:0] payload_slot_index,
    output logic [6:0] overhead_slot_index,
    output logic payload_slot_start,
    output logic overhead_slot_start
);

    typedef struct packed {
        tsbsp_lane_t pl;
        tsbsp_lane_t oh;
        logic sync;
        logic pl_start;
        logic oh_start;
    } tsbsp_state_t;

    tsbsp_state_t s_q, s_d;

    // one rising edge of the sampled link clock advances the lane one bit;
    // the overhead lane reuses this exactly, with its own pins
    function automatic tsbsp_lane_t lane_step(input tsbsp_lane_t l, input logic ck,
            input logic sb, input logic ts, input logic rd, input logic rs,
            input logic [7:0] txb, output logic start);
        tsbsp_lane_t n;
        logic rise;
        logic frame_first;
        logic sstart;
        n = l;
        start = 1'b0;
        frame_first = 1'b0;
        sstart = 1'b0;
        // first stage feeds only the second stage
        n.clk_s = {l.clk_s[0], ck};
        n.stb_s = {l.stb_s[0], sb};
        n.tst_s = {l.tst_s[0], ts};
        n.rd_s = {l.rd_s[0], rd};
        n.rst_s = {l.rst_s[0], rs};
        n.clk_prev = l.clk_s[1];
        n.rx_valid = 1'b0;
        rise = l.clk_s[1] & ~l.clk_prev;
        if (rise) begin
            frame_first = l.stb_s[1];
            sstart = frame_first || l.bitn == 3'd7 || !l.in_frame;
            // receive: sample bit launched on the previous rising edge
            // the edge that shows the strobe carries bit 7 of slot 0, so it shifts too
            if ((l.in_frame || frame_first) && !l.rst_s[1]) begin // stuffed bits dropped
                n.rx_sh = {l.rx_sh[6:0], l.rd_s[1]}; // msb first
            end
            // the eighth bit of a slot arrives on the edge before the next slot start
            if (l.in_frame && !sstart && l.bitn == 3'd6 && !l.rst_s[1]) begin
                n.rx_byte = {l.rx_sh[6:0], l.rd_s[1]};
                n.rx_valid = 1'b1;
            end
            if (sstart) begin
                n.bitn = 3'd0;
                n.in_frame = l.in_frame | frame_first;
                if (frame_first) begin
                    n.slot = 7'd0;
                end else if (l.slot == 7'(SLOTS - 1)) begin
                    n.slot = 7'd0;
                end else begin
                    n.slot = l.slot + 7'd1;
                end
                // stuff request taken at slot start, lands eight slots later
                n.stuff_pipe = {l.stuff_pipe[6:0], l.tst_s[1]};
                n.cur_stuffed = l.stuff_pipe[`TSBSP_STUFF_DELAY - 1];
                n.tx_byte = l.stuff_pipe[`TSBSP_STUFF_DELAY - 1] ?
                    `TSBSP_STUFF_BYTE : txb;
                n.txd = l.stuff_pipe[`TSBSP_STUFF_DELAY - 1] ? 1'b1 : txb[7];
                start = 1'b1;
            end else begin
                n.bitn = l.bitn + 3'd1;
                n.txd = l.tx_byte[3'd6 - l.bitn]; // launch on rising edge
            end
        end
        return n;
    endfunction

    // next state for both lanes and the sync indication
    always_comb begin
        logic pls;
        logic ohs;
        pls = 1'b0;
        ohs = 1'b0;
        s_d = s_q;
        s_d.pl = lane_step(s_q.pl, payload_bus_clock, payload_frame_strobe,
            payload_tx_stuff_request, payload_rx_serial_data, payload_rx_stuff_flag,
            payload_tx_byte, pls);
        s_d.oh = lane_step(s_q.oh, overhead_bus_clock, overhead_frame_strobe,
            overhead_tx_stuff_request, overhead_rx_serial_data, overhead_rx_stuff_flag,
            overhead_tx_byte, ohs);
        s_d.pl_start = pls;
        s_d.oh_start = ohs;
        // sync follows the slot; forced low in stuffed slots
        if (pls) begin
            s_d.sync = payload_tx_sync_req & ~s_d.pl.cur_stuffed;
        end
    end

    // registered state; asynchronous reset to constants only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.pl.txd <= `TSBSP_TXD_RST;
            s_q.oh.txd <= `TSBSP_TXD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign payload_tx_serial_data = s_q.pl.txd;
    assign overhead_tx_serial_data = s_q.oh.txd;
    assign tx_sync_indication = s_q.sync;
    assign payload_rx_byte = s_q.pl.rx_byte;
    assign payload_rx_valid = s_q.pl.rx_valid;
    assign overhead_rx_byte = s_q.oh.rx_byte;
    assign overhead_rx_valid = s_q.oh.rx_valid;
    assign payload_slot_index = s_q.pl.slot;
    assign overhead_slot_index = s_q.oh.slot;
    assign payload_slot_start = s_q.pl_start;
    assign overhead_slot_start = s_q.oh_start;

    // the overhead channel map (data links, section channels, path channels,
    // processor traffic, reserved slots) is slot content owned by the user
    // side; this port carries every unstuffed slot unchanged

    sequence s_stuff_taken;
        s_q.pl_start && s_q.pl.stuff_pipe[0];
    endsequence

    // a detected rising edge of each link clock, as seen after the synchroniser
    sequence s_pl_rise;
        s_q.pl.clk_s[1] && !s_q.pl.clk_prev;
    endsequence

    sequence s_oh_rise;
        s_q.oh.clk_s[1] && !s_q.oh.clk_prev;
    endsequence

    // last bit of a slot, on a link edge that does not show the frame strobe
    sequence s_pl_slot_end;
        s_pl_rise ##0 (s_q.pl.in_frame && s_q.pl.bitn == 3'd7 && !s_q.pl.stb_s[1]);
    endsequence

    // tx bits move only on link edges, so the master sees them settled
    a_tx_bit_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        $changed(payload_tx_serial_data)
            |-> $past(s_q.pl.clk_s[1] && !s_q.pl.clk_prev))
        else $error("payload tx bit moved between link edges");
    a_oh_tx_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        $changed(overhead_tx_serial_data)
            |-> $past(s_q.oh.clk_s[1] && !s_q.oh.clk_prev))
        else $error("overhead tx bit moved between link edges");
    a_rx_after_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
        payload_rx_valid |-> $past(s_q.pl.clk_s[1] && !s_q.pl.clk_prev))
        else $error("payload byte delivered off a link edge");
    a_oh_rx_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
        overhead_rx_valid |-> $past(s_q.oh.clk_s[1] && !s_q.oh.clk_prev))
        else $error("overhead byte delivered off a link edge");
    // pulses last one cycle; a longer one would deliver a byte twice
    a_valid_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        payload_rx_valid |=> !payload_rx_valid)
        else $error("payload valid longer than one cycle");
    a_oh_valid_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        overhead_rx_valid |=> !overhead_rx_valid)
        else $error("overhead valid longer than one cycle");
    a_start_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        payload_slot_start |=> !payload_slot_start)
        else $error("payload slot start longer than one cycle");
    a_oh_start_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        overhead_slot_start |=> !overhead_slot_start)
        else $error("overhead slot start longer than one cycle");
    // slot counter steps by one and wraps after the last slot of the frame
    a_slot_advance: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_pl_slot_end ##0 s_q.pl.slot != 7'(SLOTS - 1))
            |=> payload_slot_index == $past(payload_slot_index) + 7'd1)
        else $error("payload slot counter skipped");
    a_slot_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_pl_slot_end ##0 s_q.pl.slot == 7'(SLOTS - 1))
            |=> payload_slot_index == 7'd0)
        else $error("payload slot counter did not wrap");
    a_clean_msb: assert property (@(posedge sys_clk) disable iff (!nrst)
        (payload_slot_start && !s_q.pl.cur_stuffed)
            |-> payload_tx_serial_data == s_q.pl.tx_byte[7])
        else $error("slot did not open with its msb");
    a_oh_strobe_slot0: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_oh_rise ##0 s_q.oh.stb_s[1])
            |=> overhead_slot_start && overhead_slot_index == 7'd0)
        else $error("overhead strobe did not restart frame");
    a_oh_rx_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_oh_rise ##0 s_q.oh.rst_s[1]) |=> !overhead_rx_valid)
        else $error("overhead stuffed receive bits accepted");
    a_oh_slot_range: assert property (@(posedge sys_clk) disable iff (!nrst)
        overhead_slot_index < 7'(SLOTS))
        else $error("overhead slot index out of frame");
    a_oh_stuff_first: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_q.oh_start && s_q.oh.cur_stuffed) |-> overhead_tx_serial_data)
        else $error("overhead stuffed slot msb not one");

    a_sync_in_stuff: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_q.pl.cur_stuffed |-> !tx_sync_indication)
        else $error("sync high in stuffed slot");
    a_stuff_ones_first: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_q.pl_start && s_q.pl.cur_stuffed) |-> payload_tx_serial_data)
        else $error("stuffed slot msb not one");
    a_stuff_byte_val: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_q.pl.cur_stuffed |-> s_q.pl.tx_byte == `TSBSP_STUFF_BYTE)
        else $error("stuffed slot byte not all ones");
    a_stuff_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_stuff_taken |-> s_q.pl.stuff_pipe[7] == $past(s_q.pl.stuff_pipe[6]))
        else $error("stuff delay line broken");
    a_slot_range: assert property (@(posedge sys_clk) disable iff (!nrst)
        payload_slot_index < 7'(SLOTS))
        else $error("slot index out of frame");
    a_rx_stuff_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_q.pl.rst_s[1] && s_q.pl.clk_s[1] && !s_q.pl.clk_prev) |=> !payload_rx_valid)
        else $error("stuffed receive bits accepted");
    a_strobe_slot0: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_q.pl.stb_s[1] && s_q.pl.clk_s[1] && !s_q.pl.clk_prev)
            |=> payload_slot_start && payload_slot_index == 7'd0)
        else $error("strobe did not restart frame");
    a_oh_stuff_ones: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_q.oh.cur_stuffed |-> s_q.oh.tx_byte == `TSBSP_STUFF_BYTE)
        else $error("overhead stuffed slot not ones");
    a_sync_nonstuff: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(tx_sync_indication) |-> payload_slot_start && !s_q.pl.cur_stuffed)
        else $error("sync rose outside a clean slot start");

endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsbsp_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic pclk, pstb, ptst, prd, prs, ptd, psync, oclk, ostb, otst, ord, ors, otd;
    logic [7:0] ptb = 8'h1E;
    logic [7:0] otb = 8'hC2;
    logic psreq = 1'b1;
    logic [7:0] prb, orb;
    logic prv, orv;
    logic [7:0] pq [$];
    logic [7:0] oq [$];
    int n_fail = 0;
    int samples_checked = 0;
    always #4 sys_clk = ~sys_clk;
    tsbsp_master_model pm (.lclk(pclk), .stb(pstb), .tstuff(ptst), .rdat(prd),
        .rstuff(prs), .tdat(ptd), .sync(psync));
    tsbsp_master_model om (.lclk(oclk), .stb(ostb), .tstuff(otst), .rdat(ord),
        .rstuff(ors), .tdat(otd), .sync(1'b0));
    tsbsp_slot_port dut (.sys_clk(sys_clk), .nrst(nrst), .payload_bus_clock(pclk),
        .payload_frame_strobe(pstb), .payload_tx_stuff_request(ptst),
        .payload_rx_serial_data(prd), .payload_rx_stuff_flag(prs),
        .payload_tx_serial_data(ptd), .tx_sync_indication(psync),
        .overhead_bus_clock(oclk), .overhead_frame_strobe(ostb),
        .overhead_tx_stuff_request(otst), .overhead_rx_serial_data(ord),
        .overhead_rx_stuff_flag(ors), .overhead_tx_serial_data(otd),
        .payload_tx_byte(ptb), .payload_tx_sync_req(psreq), .overhead_tx_byte(otb),
        .payload_rx_byte(prb), .payload_rx_valid(prv), .overhead_rx_byte(orb),
        .overhead_rx_valid(orv), .payload_slot_index(), .overhead_slot_index(),
        .payload_slot_start(), .overhead_slot_start());
    // collect every delivered receive byte
    always @(posedge sys_clk) begin
        if (prv === 1'b1) pq.push_back(prb);
        if (orv === 1'b1) oq.push_back(orb);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", n_fail, samples_checked);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic reset_values();
        check({7'h00, ptd}, 8'h01, "payload tx idle");
        check({7'h00, otd}, 8'h01, "overhead tx idle");
        check({6'h00, psync, prv}, 8'h00, "sync and valid idle");
    endtask
    // both buses in parallel; stuff and receive-stuff slots chosen per call
    task automatic frame_test(input int pst, input int ost, input int prsl, input int orsl);
        int k;
        pq.delete();
        oq.delete();
        fork
            pm.run_frame(pst, prsl);
            om.run_frame(ost, orsl);
        join
        repeat (16) @(posedge sys_clk);
        for (int s = 0; s < 84; s++) begin
            check(pm.tx_cap[s], (s == pst + 8) ? 8'hFF : ptb, "payload tx");
            check({7'h00, pm.sync_cap[s]}, {7'h00, s != pst + 8}, "sync");
            check(om.tx_cap[s], (s == ost + 8) ? 8'hFF : otb, "overhead tx");
        end
        check(8'(pq.size()), 8'd83, "payload rx count");
        check(8'(oq.size()), 8'd83, "overhead rx count");
        k = 0;
        for (int s = 0; s < 84; s++) if (s != prsl && k < pq.size()) begin
            check(pq[k], 8'(s) ^ 8'h5A, "payload rx");
            k++;
        end
        k = 0;
        for (int s = 0; s < 84; s++) if (s != orsl && k < oq.size()) begin
            check(oq[k], 8'(s) ^ 8'h5A, "overhead rx");
            k++;
        end
    endtask
    // watchdog: two frames take about 11000 cycles
    initial begin
        #400000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_values();
        nrst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        frame_test(0, 3, 10, 0);
        frame_test(75, 1, 83, 83);
        test_done();
    end
endmodule
`default_nettype wire

// File: dv/tsbsp_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsbsp_master_model (
    // bus signals toward the slave
    output logic lclk,
    output logic stb,
    output logic tstuff,
    output logic rdat,
    output logic rstuff,
    // bus signals from the slave
    input wire logic tdat,
    input wire logic sync
);
    logic [7:0] tx_cap [0:83];
    logic sync_cap [0:83];
    initial begin
        lclk = 1'b0;
        stb = 1'b0;
        tstuff = 1'b0;
        rdat = 1'b1;
        rstuff = 1'b0;
    end
    // one frame plus two closing edges; clock rests low between frames.
    // the slave sees the strobe one edge late, so its bits reach the master two edges late
    task automatic run_frame(input int st, input int rs);
        logic [7:0] rx;
        for (int e = 0; e <= 673; e++) begin
            lclk = 1'b1;
            if (e > 1) begin
                tx_cap[(e-2)/8][7-((e-2)%8)] = tdat;
                sync_cap[(e-2)/8] = ((e-2)%8 == 0) ? sync : (sync_cap[(e-2)/8] | sync);
            end
            // launch well after the edge so the slave's first sample of it sees old data
            #12;
            rx = 8'(e/8) ^ 8'h5A;
            stb = (e == 0);
            tstuff = (e == st*8);
            rstuff = (e/8 == rs);
            // released line shows the inverse, not a stale value
            rdat = (e >= 672) ? ~rdat : (rstuff ? 1'b1 : rx[7-(e%8)]);
            #20 lclk = 1'b0;
            #32;
        end
        stb = 1'b0;
        tstuff = 1'b0;
        rstuff = 1'b0;
    endtask
endmodule
`default_nettype wire
